// file: psl_buf2.v
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: same clock on both sides, ce_i freezes all state
// Notes:   output data come straight from the storage registers
`include "psl_consts.vh"

module psl_buf2 (
   input  wire       mclk_i,     // system clock
   input  wire       rst_n_i,    // async reset, active low
   input  wire       ce_i,       // clock enable
   input  wire [3:0] in_data_i,  // word to store
   input  wire       in_valid_i, // word offered
   output wire       in_ready_o, // room for a word
   output wire [3:0] out_data_o, // oldest word
   output wire       out_valid_o,// a word is held
   input  wire       out_ready_i // drain takes the word
);

   reg  [3:0] mem0;
   reg  [3:0] mem1;
   reg        wr_ptr;
   reg        rd_ptr;
   reg  [1:0] count;
   wire       push;
   wire       pop;

   // honest full and empty straight from the count
   assign in_ready_o  = (count != 2'h2);
   assign out_valid_o = (count != 2'h0);
   assign out_data_o  = rd_ptr ? mem1 : mem0;
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   ////////////////////////////////////////////////////////////////////////
   // storage and pointers
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem0   <= 4'h0;
         mem1   <= 4'h0;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else if (ce_i) begin
         if (push) begin
            if (wr_ptr)
               mem1 <= in_data_i;
            else
               mem0 <= in_data_i;
            wr_ptr <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         // simultaneous push and pop leaves the count alone
         if (push & ~pop)
            count <= count + 2'h1;
         else if (pop & ~push)
            count <= count - 2'h1;
      end
   end

endmodule

// file: psl_consts.vh
// Purpose: shared constants for the strap latch and indicator block
// Assumes: 100 MHz system clock
// Notes:   field positions name the control register bits that the
//          latched straps stand for
`ifndef PSL_CONSTS_VH
`define PSL_CONSTS_VH

// clock and timing
`define PSL_CLK_NS        10
`define PSL_BLINK_NS      50000000
`define PSL_FILL_CYC      3'h4

// indicator mode field, vendor control register 1fh bits 5:4
`define PSL_LED_MODE_HI   5
`define PSL_LED_MODE_LO   4
`define PSL_LED_SPEED     2'h0
`define PSL_LED_ACT       2'h1

// interface mode strap encodings
`define PSL_IF_STD        3'h0
`define PSL_IF_B2B        3'h6

// register bit positions fed by the straps
`define PSL_CTL_SPEED_BIT 13
`define PSL_CTL_ISO_BIT   10
`define PSL_BCAST_OFF_BIT 9

// strap defaults used until the first latch
`define PSL_ADDR_RST      3'h1
`define PSL_ADDR_HI_RST   2'h0
`define PSL_SPEED_RST     1'b1
`define PSL_ISO_RST       1'b0
`define PSL_BCAST_RST     1'b0
`define PSL_MODE_RST      3'h0

// synchroniser vector layout
`define PSL_SYNC_W        16
`define PSL_S_SPEED       0
`define PSL_S_ADDR        1
`define PSL_S_BCAST       4
`define PSL_S_MODE        5
`define PSL_S_ISO         8
`define PSL_S_RXCLK       9
`define PSL_S_TXCLK       10
`define PSL_S_TXD         11
`define PSL_S_TXEN        15

`endif

// file: psl_mac_model.sv
// Purpose: mac side of the nibble interface, makes both link clocks
// Assumes: 125 ns link clock period
// Notes:   clocks stand low between transfers
module psl_mac_model (
   output logic       tx_clk_o, // transmit clock
   output logic [3:0] txd_o,    // transmit nibble
   output logic       tx_en_o,  // transmit enable
   output logic       rx_clk_o, // receive clock
   input  wire  [3:0] rxd_i,    // receive nibble
   input  wire        rx_dv_i   // receive data valid
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] got[$];          // nibbles seen valid
   ////////////////////////////////////////////////////////////////////////////////
   // idle levels at time zero
   initial begin
      tx_clk_o = 1'b0;
      txd_o = 4'h0;
      tx_en_o = 1'b0;
      rx_clk_o = 1'b0;
   end
   task automatic send(input logic [3:0] nib, input logic en);
      txd_o <= nib;
      tx_en_o <= en;
      #62.5 tx_clk_o <= 1'b1;
      #62.5 tx_clk_o <= 1'b0;
   endtask
   // receive clock only while asked
   task automatic rx_cycles(input int n);
      repeat (n) begin
         #62.5 rx_clk_o <= 1'b1;
         #62.5 rx_clk_o <= 1'b0;
      end
   endtask
   always @(posedge rx_clk_o) begin
      if (rx_dv_i === 1'b1)
         got.push_back(rxd_i);
   end
endmodule

// file: psl_strap_latch.v
// Purpose: latch transceiver pin straps at reset release, drive the
//          speed/activity indicator and the nibble data paths
// Assumes: 100 MHz mclk_i; link clocks and pins are asynchronous
// Notes:   strap pins are split into input, output and output enable
//
// Behaviour
// - While reset is held the dual-purpose pins are inputs, and after release they drive.
// - The indicator pin level is captured as the speed setting when reset is released.
// - A two-bit indicator mode field (bits 5:4 of register 1fh) picks the indicator behaviour.
// - Mode 00 shows high for 10 and low for 100, mode 01 idles high and toggles on activity.
// - The receive nibble moves with the receive clock and is valid only while data-valid is high.
// - The transmit nibble is taken on the transmit clock only while transmit enable is high.
// - The low three management address bits are latched from straps, default 1.
// - The upper two management address bits are always 00.
// - Address zero is broadcast unless the disable strap or bit 9 of register 16h is set.
// - A three-bit interface mode is latched, 000 standard and 110 back-to-back, others reserved.
// - The speed strap feeds control bit 13 and the speed capability advertised in register 4h.
// - The isolate strap feeds bit 10 of control register 0h, default not isolated.
`include "psl_consts.vh"

module psl_strap_latch #(
   parameter BLINK_CYC = `PSL_BLINK_NS / `PSL_CLK_NS
) (
   input  wire       mclk_i,                  // system clock
   input  wire       rst_n_i,                 // async chip reset, active low
   input  wire       ce_i,                    // clock enable
   input  wire       speed_pin_i,             // indicator/speed pin level
   output wire       speed_pin_o,             // indicator drive value
   output wire       speed_pin_oe_o,          // indicator drive enable
   input  wire [2:0] mgmt_addr_strap_i,       // address strap pin levels
   output wire [2:0] mgmt_addr_strap_o,       // address pin drive values
   output wire       mgmt_addr_strap_oe_o,    // address pin drive enable
   input  wire       broadcast_disable_strap_i,  // broadcast-off pin level
   output wire       broadcast_disable_strap_o,  // broadcast-off drive value
   output wire       broadcast_disable_strap_oe_o, // broadcast-off enable
   input  wire [2:0] iface_mode_strap_i,      // interface mode pin levels
   output wire [2:0] iface_mode_strap_o,      // mode pin drive values
   output wire       iface_mode_strap_oe_o,   // mode pin drive enable
   input  wire       isolate_strap_i,         // isolate pin level
   output wire       isolate_strap_o,         // isolate pin drive value
   output wire       isolate_strap_oe_o,      // isolate pin drive enable
   input  wire [7:0] pin_out_i,               // normal output values of strap pins
   input  wire [1:0] led_mode_i,              // indicator mode field
   input  wire       link_speed_100_i,        // link runs at 100 Mbit/s
   input  wire       activity_i,              // traffic seen on the line
   input  wire       bcast_off_reg_i,         // register bit making addr 0 unique
   input  wire       rx_clk_i,                // receive link clock
   input  wire [3:0] rx_data_i,               // receive nibble from the core
   input  wire       rx_valid_i,              // receive nibble offered
   output wire       rx_ready_o,              // buffer can take a nibble
   output reg  [3:0] rxd_o,                   // receive nibble to the mac
   output reg        rx_dv_o,                 // receive data valid
   input  wire       tx_clk_i,                // transmit link clock
   input  wire [3:0] txd_i,                   // transmit nibble from the mac
   input  wire       tx_en_i,                 // transmit enable
   output reg  [3:0] tx_data_o,               // accepted transmit nibble
   output reg        tx_valid_o,              // one-cycle pulse per nibble
   output wire [4:0] mgmt_addr_o,             // management address
   output wire       bcast_addr0_o,           // address zero is broadcast
   output wire       speed_100_o,             // control speed select bit
   output wire       adv_100_o,               // advertise 100 Mbit/s
   output wire       isolate_o,               // control isolate bit
   output wire [2:0] iface_mode_o,            // latched interface mode
   output wire       back_to_back_o,          // repeater mode selected
   output wire       iface_reserved_o,        // reserved mode strapped
   output wire       straps_done_o            // straps latched, pins driving
);

   localparam ST_FILL = 2'h0;
   localparam ST_RUN  = 2'h1;

   reg  [`PSL_SYNC_W-1:0] sync1;
   reg  [`PSL_SYNC_W-1:0] sync2;
   reg  [`PSL_SYNC_W-1:0] sync3;
   reg  [`PSL_SYNC_W-1:0] stab;
   wire [`PSL_SYNC_W-1:0] raw;
   wire [`PSL_SYNC_W-1:0] agree;
   reg  [1:0]             state;
   reg  [2:0]             fill_cnt;
   reg  [2:0]             addr_lat;
   reg                    speed_lat;
   reg                    bcast_lat;
   reg  [2:0]             mode_lat;
   reg                    iso_lat;
   reg  [31:0]            blink_cnt;
   reg                    blink;
   reg                    led_val;
   wire                   running;
   wire                   rx_fall;
   wire                   tx_rise;
   wire [3:0]             buf_data;
   wire                   buf_valid;
   wire                   buf_pop;

   assign raw = {tx_en_i, txd_i, tx_clk_i, rx_clk_i, isolate_strap_i,
                 iface_mode_strap_i, broadcast_disable_strap_i,
                 mgmt_addr_strap_i, speed_pin_i};

   ////////////////////////////////////////////////////////////////////////
   // three-stage synchronisers; a change counts when stages 2 and 3 agree
   genvar gi;
   generate
      for (gi = 0; gi < `PSL_SYNC_W; gi = gi + 1) begin : g_sync
         assign agree[gi] = (sync2[gi] == sync3[gi]);
         always @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
               stab[gi]  <= 1'b0;
            end else if (ce_i) begin
               sync1[gi] <= raw[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (agree[gi])
                  stab[gi] <= sync3[gi];
            end
         end
      end
   endgenerate

   // edges of the sampled link clocks
   assign rx_fall = agree[`PSL_S_RXCLK] & ~sync3[`PSL_S_RXCLK] & stab[`PSL_S_RXCLK];
   assign tx_rise = agree[`PSL_S_TXCLK] & sync3[`PSL_S_TXCLK] & ~stab[`PSL_S_TXCLK];

   ////////////////////////////////////////////////////////////////////////
   // strap capture sequence; the chain must fill before the first latch,
   // since async reset may only load constants into the flops
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state     <= ST_FILL;
         fill_cnt  <= 3'h0;
         addr_lat  <= `PSL_ADDR_RST;
         speed_lat <= `PSL_SPEED_RST;
         bcast_lat <= `PSL_BCAST_RST;
         mode_lat  <= `PSL_MODE_RST;
         iso_lat   <= `PSL_ISO_RST;
      end else if (ce_i) begin
         case (state)
            ST_FILL: begin
               if (fill_cnt == `PSL_FILL_CYC) begin
                  state     <= ST_RUN;
                  speed_lat <= stab[`PSL_S_SPEED];
                  addr_lat  <= stab[`PSL_S_ADDR+2:`PSL_S_ADDR];
                  bcast_lat <= stab[`PSL_S_BCAST];
                  mode_lat  <= stab[`PSL_S_MODE+2:`PSL_S_MODE];
                  iso_lat   <= stab[`PSL_S_ISO];
               end else begin
                  fill_cnt <= fill_cnt + 3'h1;
               end
            end
            ST_RUN:  state <= ST_RUN;
            default: state <= ST_FILL;
         endcase
      end
   end

   assign running       = (state == ST_RUN);
   assign straps_done_o = running;

   ////////////////////////////////////////////////////////////////////////
   // configuration outputs
   // upper address bits fixed
   assign mgmt_addr_o      = {`PSL_ADDR_HI_RST, addr_lat};
   assign bcast_addr0_o    = ~(bcast_lat | bcast_off_reg_i);
   assign speed_100_o      = speed_lat;
   assign adv_100_o        = speed_lat;
   assign isolate_o        = iso_lat;
   assign iface_mode_o     = mode_lat;
   assign back_to_back_o   = (mode_lat == `PSL_IF_B2B);
   assign iface_reserved_o = (mode_lat != `PSL_IF_B2B) && (mode_lat != `PSL_IF_STD);

   ////////////////////////////////////////////////////////////////////////
   // pins turn to outputs once straps are latched
   assign mgmt_addr_strap_oe_o         = running;
   assign broadcast_disable_strap_oe_o = running;
   assign iface_mode_strap_oe_o        = running;
   assign isolate_strap_oe_o           = running;
   assign speed_pin_oe_o               = running;
   assign mgmt_addr_strap_o            = pin_out_i[2:0];
   assign broadcast_disable_strap_o    = pin_out_i[3];
   assign iface_mode_strap_o           = pin_out_i[6:4];
   assign isolate_strap_o              = pin_out_i[7];
   assign speed_pin_o                  = led_val;

   ////////////////////////////////////////////////////////////////////////
   // blink timer; restarts when idle so the first toggle has full length
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         blink_cnt <= 32'h0;
         blink     <= 1'b0;
      end else if (ce_i) begin
         if (!activity_i) begin
            blink_cnt <= 32'h0;
            blink     <= 1'b0;
         end else if (blink_cnt >= BLINK_CYC - 1) begin
            blink_cnt <= 32'h0;
            blink     <= ~blink;
         end else begin
            blink_cnt <= blink_cnt + 32'h1;
         end
      end
   end

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         led_val <= 1'b1;
      end else if (ce_i) begin
         case (led_mode_i)
            // high for 10, low for 100
            `PSL_LED_SPEED: led_val <= ~link_speed_100_i;
            `PSL_LED_ACT:   led_val <= ~blink;
            // reserved modes keep the indicator off
            default:        led_val <= 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive path; the buffer absorbs core words between link edges
   assign buf_pop = running & rx_fall;

   psl_buf2 u_rx_buf (
      .mclk_i      (mclk_i),
      .rst_n_i     (rst_n_i),
      .ce_i        (ce_i),
      .in_data_i   (rx_data_i),
      .in_valid_i  (rx_valid_i),
      .in_ready_o  (rx_ready_o),
      .out_data_o  (buf_data),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_pop)
   );

   // nibble changes on the falling receive edge, valid with dv
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rxd_o   <= 4'h0;
         rx_dv_o <= 1'b0;
      end else if (ce_i && buf_pop) begin
         rx_dv_o <= buf_valid;
         if (buf_valid)
            rxd_o <= buf_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit nibble taken on the rising edge only with enable
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_data_o  <= 4'h0;
         tx_valid_o <= 1'b0;
      end else if (ce_i) begin
         tx_valid_o <= running & tx_rise & stab[`PSL_S_TXEN];
         if (running && tx_rise && stab[`PSL_S_TXEN])
            tx_data_o <= stab[`PSL_S_TXD+3:`PSL_S_TXD];
      end
   end

endmodule

// file: psl_strap_latch_bench.sv
// Purpose: self-checking bench for the strap latch block
// Assumes: 100 MHz mclk_i, link clocks from the mac model
// Notes:   board pulls show on a pin only while the block is not driving
`include "psl_consts.vh"
`define PSL_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
$display("FAIL %s expected %h seen %h", nm, (e), (g)); end end
module psl_strap_latch_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int BLINK = 4;    // short blink keeps the run brief
   int n_mismatch, compares, i, ch;
   logic [2:0] v, pull_addr, pull_mode;
   logic pull_spd, pull_bc, pull_iso, last;
   logic [3:0] txq[$];
   logic [3:0] tx_nib[5] = '{4'ha, 4'h5, 4'hc, 4'h3, 4'h9};
   logic mclk_i, rst_n_i, ce_i, speed_pin_i, speed_pin_o, speed_pin_oe_o;
   logic [2:0] mgmt_addr_strap_i, mgmt_addr_strap_o, iface_mode_strap_i, iface_mode_strap_o;
   logic mgmt_addr_strap_oe_o, broadcast_disable_strap_i, broadcast_disable_strap_o;
   logic broadcast_disable_strap_oe_o, iface_mode_strap_oe_o;
   logic isolate_strap_i, isolate_strap_o, isolate_strap_oe_o;
   logic [7:0] pin_out_i;
   logic [1:0] led_mode_i;
   logic link_speed_100_i, activity_i, bcast_off_reg_i, rx_clk_i, rx_valid_i, rx_ready_o;
   logic [3:0] rx_data_i, rxd_o, txd_i, tx_data_o;
   logic rx_dv_o, tx_clk_i, tx_en_i, tx_valid_o, bcast_addr0_o, speed_100_o, adv_100_o;
   logic isolate_o, back_to_back_o, iface_reserved_o, straps_done_o;
   logic [4:0] mgmt_addr_o;
   logic [2:0] iface_mode_o;
   logic [7:0] pins;            // strap pin levels but the speed pin, pin_out_i order
   ////////////////////////////////////////////////////////////////////////////////
   // pin level from the block's enable and the board pull
   assign speed_pin_i = speed_pin_oe_o ? speed_pin_o : pull_spd;
   assign mgmt_addr_strap_i = mgmt_addr_strap_oe_o ? mgmt_addr_strap_o : pull_addr;
   assign broadcast_disable_strap_i = broadcast_disable_strap_oe_o ? broadcast_disable_strap_o
                                                                  : pull_bc;
   assign iface_mode_strap_i = iface_mode_strap_oe_o ? iface_mode_strap_o : pull_mode;
   assign isolate_strap_i = isolate_strap_oe_o ? isolate_strap_o : pull_iso;
   assign pins = {isolate_strap_i, iface_mode_strap_i, broadcast_disable_strap_i,
                  mgmt_addr_strap_i};
   psl_strap_latch #(.BLINK_CYC(BLINK)) DUT (.*);
   psl_mac_model mac (.tx_clk_o(tx_clk_i), .txd_o(txd_i), .tx_en_o(tx_en_i),
                      .rx_clk_o(rx_clk_i), .rxd_i(rxd_o), .rx_dv_i(rx_dv_o));
   ////////////////////////////////////////////////////////////////////////////////
   // system clock
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // accepted transmit nibbles, read once settled
   always @(negedge mclk_i) begin
      if (tx_valid_o === 1'b1)
         txq.push_back(tx_data_o);
   end
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // reset with straps set, then wait for the latch
   task automatic strap_reset(input logic [2:0] s);
      int n;
      {pull_iso, pull_spd, pull_bc} <= s;
      pull_addr <= s;
      pull_mode <= s;
      rst_n_i <= 1'b0;
      repeat (4) @(negedge mclk_i);
      `PSL_CHK("oe_rst", 1'b0, mgmt_addr_strap_oe_o)
      `PSL_CHK("addr_rst", 5'h01, mgmt_addr_o)
      @(posedge mclk_i);
      rst_n_i <= 1'b1;
      n = 0;
      while (straps_done_o !== 1'b1 && n < 20) begin
         @(negedge mclk_i);
         n++;
      end
      `PSL_CHK("done", 1'b1, straps_done_o)
   endtask
   // offer a word, held until taken; caller lowers valid
   task automatic rx_push(input logic [3:0] w);
      int n;
      rx_data_i <= w;
      rx_valid_i <= 1'b1;
      n = 0;
      @(negedge mclk_i);
      while (rx_ready_o !== 1'b1 && n < 400) begin
         @(negedge mclk_i);
         n++;
      end
      `PSL_CHK("rx_rdy", 1'b1, rx_ready_o)
      @(posedge mclk_i);
   endtask
   // watchdog well beyond the expected run
   initial begin
      #100000;
      n_mismatch++;
      stop_test();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {n_mismatch, compares, rst_n_i, pin_out_i, led_mode_i, activity_i} = '0;
      {link_speed_100_i, bcast_off_reg_i, rx_data_i, rx_valid_i, ce_i} = 8'h01;
      {pull_addr, pull_mode, pull_spd, pull_bc, pull_iso} = '0;
      // every strap value, one per reset
      for (i = 0; i < 8; i++) begin
         v = i[2:0];
         @(posedge mclk_i);
         strap_reset(v);
         `PSL_CHK("addr", {2'h0, v}, mgmt_addr_o)
         `PSL_CHK("speed", v[1], speed_100_o)
         `PSL_CHK("adv", v[1], adv_100_o)
         `PSL_CHK("iso", v[2], isolate_o)
         `PSL_CHK("mode", {v == `PSL_IF_B2B, v}, {back_to_back_o, iface_mode_o})
         `PSL_CHK("rsv", v != `PSL_IF_STD && v != `PSL_IF_B2B, iface_reserved_o)
         `PSL_CHK("bcast", ~v[0], bcast_addr0_o)
         @(posedge mclk_i);
         bcast_off_reg_i <= 1'b1;
         pin_out_i <= ~{v[2], v, v[0], v};
         repeat (3) @(negedge mclk_i);
         `PSL_CHK("bc_reg", 1'b0, bcast_addr0_o)
         `PSL_CHK("hold", {2'h0, v, v}, {mgmt_addr_o, iface_mode_o})
         `PSL_CHK("pin", ~{v[2], v, v[0], v}, pins)
         @(posedge mclk_i);
         bcast_off_reg_i <= 1'b0;
      end
      // indicator modes
      @(posedge mclk_i);
      link_speed_100_i <= 1'b1;
      repeat (2) @(negedge mclk_i);
      `PSL_CHK("led_100", 1'b0, speed_pin_o)
      @(posedge mclk_i);
      link_speed_100_i <= 1'b0;
      repeat (2) @(negedge mclk_i);
      `PSL_CHK("led_10", 1'b1, speed_pin_o)
      @(posedge mclk_i);
      led_mode_i <= `PSL_LED_ACT;
      repeat (2) @(negedge mclk_i);
      `PSL_CHK("led_idle", 1'b1, speed_pin_o)
      @(posedge mclk_i);
      activity_i <= 1'b1;
      ch = 0;
      @(negedge mclk_i);
      last = speed_pin_o;
      repeat (12) begin
         @(negedge mclk_i);
         if (speed_pin_o !== last)
            ch++;
         last = speed_pin_o;
      end
      `PSL_CHK("blink", 1'b1, ch >= 2 && ch <= 3)
      // a low clock enable must freeze the blinking pin
      @(posedge mclk_i);
      ce_i <= 1'b0;
      @(negedge mclk_i);
      last = speed_pin_o;
      repeat (10) @(negedge mclk_i);
      `PSL_CHK("ce_hold", last, speed_pin_o)
      @(posedge mclk_i);
      ce_i <= 1'b1;
      for (i = 2; i < 4; i++) begin
         @(posedge mclk_i);
         led_mode_i <= i[1:0];
         repeat (3) @(negedge mclk_i);
         `PSL_CHK("led_rsv", 1'b1, speed_pin_o)
      end
      @(posedge mclk_i);
      activity_i <= 1'b0;
      // transmit: the last two nibbles go without enable
      txq.delete();
      for (i = 0; i < 5; i++)
         mac.send(tx_nib[i], i < 3);
      repeat (10) @(negedge mclk_i);
      `PSL_CHK("tx_n", 32'd3, txq.size())
      for (i = 0; i < 3; i++)
         `PSL_CHK("txd", tx_nib[i], txq[i])
      // receive: fill the buffer, then drain it through the link
      @(posedge mclk_i);
      rx_push(4'h1);
      rx_push(4'h2);
      @(negedge mclk_i);
      `PSL_CHK("rx_full", 1'b0, rx_ready_o)
      @(posedge mclk_i);
      fork
         begin
            rx_push(4'h3);
            rx_valid_i <= 1'b0;
         end
         mac.rx_cycles(8);
      join
      mac.rx_cycles(4);
      `PSL_CHK("rx_n", 32'd3, mac.got.size())
      for (i = 0; i < 3; i++)
         `PSL_CHK("rxd", i[3:0] + 4'h1, mac.got[i])
      `PSL_CHK("rx_dv", 1'b0, rx_dv_o)
      stop_test();
   end
endmodule

// file: psl_strap_latch_sva.sv
// Purpose: port checks on the strap latch block
// Assumes: one mclk_i domain, async active-low reset
// Notes:   latched values are judged once straps_done_o is high
module psl_strap_latch_sva (
   input wire       mclk_i,                       // system clock
   input wire       rst_n_i,                      // chip reset
   input wire       straps_done_o,                // straps latched
   input wire       speed_pin_oe_o,               // pin enables
   input wire       mgmt_addr_strap_oe_o,
   input wire       broadcast_disable_strap_oe_o,
   input wire       iface_mode_strap_oe_o,
   input wire       isolate_strap_oe_o,
   input wire [4:0] mgmt_addr_o,                  // latched config
   input wire       bcast_addr0_o,
   input wire       bcast_off_reg_i,
   input wire       speed_100_o,
   input wire       adv_100_o,
   input wire       isolate_o,
   input wire [2:0] iface_mode_o,
   input wire       back_to_back_o,
   input wire       iface_reserved_o,
   input wire [1:0] led_mode_i,                   // indicator control
   input wire       link_speed_100_i,
   input wire       activity_i,
   input wire       speed_pin_o,
   input wire       tx_valid_o,                   // data paths
   input wire       rx_dv_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////////////
   AST_PIN_OE: assert property ({5{straps_done_o}} == {speed_pin_oe_o,
      mgmt_addr_strap_oe_o, broadcast_disable_strap_oe_o, iface_mode_strap_oe_o,
      isolate_strap_oe_o}) else $error("pin enable differs from latch state");
   AST_SPEED_IND: assert property (led_mode_i == 2'h0 && straps_done_o ##1
      led_mode_i == 2'h0 |-> speed_pin_o == !$past(link_speed_100_i))
      else $error("speed indicator level wrong");
   AST_ACT_IDLE: assert property ((led_mode_i == 2'h1 && !activity_i) [*3]
      |-> speed_pin_o) else $error("idle activity indicator not high");
   AST_LED_RSV: assert property (led_mode_i[1] [*2] |-> speed_pin_o)
      else $error("reserved indicator mode not high");
   AST_HOLD: assert property (straps_done_o |=>
      $stable({mgmt_addr_o, speed_100_o, isolate_o, iface_mode_o}))
      else $error("latched strap value changed");
   AST_ADDR_HI: assert property (mgmt_addr_o[4:3] == 2'h0)
      else $error("upper address bits not zero");
   AST_BCAST_REG: assert property (bcast_off_reg_i |-> !bcast_addr0_o)
      else $error("address zero broadcast despite register bit");
   AST_ADV: assert property (speed_100_o == adv_100_o)
      else $error("advertised speed differs from speed select");
   AST_MODE: assert property (back_to_back_o == (iface_mode_o == 3'h6) &&
      iface_reserved_o == !(iface_mode_o == 3'h0 || iface_mode_o == 3'h6))
      else $error("interface mode decode wrong");
   AST_TX_PULSE: assert property (tx_valid_o |-> straps_done_o ##1 !tx_valid_o)
      else $error("transmit pulse too long or early");
   AST_RX_DV: assert property ($rose(rx_dv_o) |-> (straps_done_o && rx_dv_o) [*8])
      else $error("receive valid too short or early");
endmodule
bind psl_strap_latch psl_strap_latch_sva u_sva (.*);
